// file: dcsb_consts.svh
// Constants for the double-data-rate common-I/O memory port, burst of two.
// Assumes inclusion by bare name from the interface, the checker, both ends and the bench.
// Function
// R1 - True clock rise captures address, controls, first beat.
// R2 - Complement clock rise captures second beat data.
// R3 - Every access moves exactly two beats.
// R4 - First read beat at third true rise.
// R5 - Second read beat at third complement rise.
// R6 - Write data follows command by one cycle.
// R7 - Per-beat byte enables select written bytes.
// R8 - Commands on true rises, data on both.
// R9 - Device drives shared bus only returning reads.
// R10 - Word width 36 or 18 by configuration.
// R11 - Echo clocks aligned with driven read data.
// R12 - Array access completes self-timed after command.
// R13 - Load low starts transfer; select high reads.
// R14 - Valid flag marks read data, echo aligned.
// R15 - Delay loop off gives one-cycle latency.
// R16 - Address ignored unless load selects device.
// R17 - Reads merge pending buffered write bytes.
// R18 - Controller releases bus during read returns.
`ifndef DCSB_CONSTS_SVH
`define DCSB_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define DCSB_BURST_LEN 2
`define DCSB_BYTE_W 9
`define DCSB_DW_WIDE 36
`define DCSB_DW_NARROW 18
`define DCSB_AW_WIDE 20
`define DCSB_AW_NARROW 21

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DCSB_SYS_PERIOD_NS 25
`define DCSB_K_HALF_NS 100
`define DCSB_K_HALF_CYC (`DCSB_K_HALF_NS / `DCSB_SYS_PERIOD_NS)
`define DCSB_GAP_WRITE 3'h2
`define DCSB_GAP_READ 3'h4

`endif

// file: dcsb_controller.sv
// Controller end: makes the input clock pair, issues commands, drives write beats, catches reads.
// Assumes a 40 MHz sys_clk and a user side on the same clock; link inputs are synchronised here.
`timescale 1ns/1ps
`include "dcsb_consts.svh"
module dcsb_controller #(
  parameter bit WIDE_MODE = 1'b1
) (
  input wire logic sys_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  dcsb_link_if.controller link, // Memory link.
  input wire logic reqValid, // Request waiting.
  input wire logic reqWrite, // Request is a write.
  input wire logic [(WIDE_MODE ? `DCSB_AW_WIDE : `DCSB_AW_NARROW)-1:0] reqAddr, // Burst address.
  input wire logic [(WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW)-1:0] reqData0, // First write beat.
  input wire logic [(WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW)-1:0] reqData1, // Second write beat.
  input wire logic [(WIDE_MODE ? 4 : 2)-1:0] reqByteN0, // First beat byte enables, low active.
  input wire logic [(WIDE_MODE ? 4 : 2)-1:0] reqByteN1, // Second beat byte enables, low active.
  input wire logic dllOffReqN, // Low asks the device to bypass its delay loop.
  output logic reqReady, // Pulse: request taken.
  output logic rdValid, // Pulse: read burst returned.
  output logic [(WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW)-1:0] rdData0, // First read beat.
  output logic [(WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW)-1:0] rdData1 // Second read beat.
);
  localparam int DW = WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW;
  localparam int AW = WIDE_MODE ? `DCSB_AW_WIDE : `DCSB_AW_NARROW;
  localparam int BN = DW / `DCSB_BYTE_W;
  localparam int HALF = `DCSB_K_HALF_CYC;
  localparam int PW = $clog2(2 * HALF);
  localparam logic [PW-1:0] PH_LAST = PW'(2 * HALF - 1);
  localparam logic [PW-1:0] PH_SETUP = PW'(HALF + HALF / 2);
  localparam logic [PW-1:0] PH_BEAT1 = PW'(HALF / 2);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [PW-1:0] ph_q, ph_d;
  logic kT_q, kT_d, kC_q, kC_d;
  dcsb_pkg::dcsb_ctrl_state_e st_q, st_d;
  logic [2:0] gap_q, gap_d;
  logic [1:0] wStage_q, wStage_d;
  logic loadN_q, loadN_d, rw_q, rw_d, oe_q, oe_d, dll_q, dll_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [BN-1:0] bw_q, bw_d, hB0_q, hB0_d, hB1_q, hB1_d;
  logic [DW-1:0] dq_q, dq_d, hD1_q, hD1_d;
  logic rdy_q, rdy_d, rv_q, rv_d, got0_q, got0_d;
  logic [DW-1:0] r0_q, r0_d, r1_q, r1_d;
  logic eT1_q, eT2_q, eT3_q, eC1_q, eC2_q, eC3_q, qv1_q, qv2_q;
  logic [DW-1:0] dqS1_q, dqS2_q;

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  // Echo clocks, valid flag and data all take the same two flops, so they stay aligned.
  always_ff @(posedge sys_clk) begin
    eT1_q <= link.echoClockTrue;
    eT2_q <= eT1_q;
    eT3_q <= eT2_q;
    eC1_q <= link.echoClockComp;
    eC2_q <= eC1_q;
    eC3_q <= eC2_q;
    qv1_q <= link.readValidFlag;
    qv2_q <= qv1_q;
    dqS1_q <= link.dqBus;
    dqS2_q <= dqS1_q;
  end

  // ----------------------------------------------------------------
  // Clock divider, command issue and write beats
  // ----------------------------------------------------------------
  // Commands and first beats change mid way through the low half of the true clock, second beats
  // mid way through its high half, so every value is steady around the edge that samples it.
  always_comb begin
    ph_d = (ph_q == PH_LAST) ? '0 : ph_q + PW'(1);
    kT_d = (ph_d < PW'(HALF)); // R8
    kC_d = !kT_d; // R2
    st_d = st_q;
    gap_d = gap_q;
    wStage_d = wStage_q;
    loadN_d = loadN_q;
    rw_d = rw_q;
    addr_d = addr_q;
    bw_d = bw_q;
    dq_d = dq_q;
    oe_d = oe_q;
    hD1_d = hD1_q;
    hB0_d = hB0_q;
    hB1_d = hB1_q;
    rdy_d = 1'b0;
    dll_d = dllOffReqN;
    if (ph_d == PH_SETUP) begin
      loadN_d = 1'b1;
      if (wStage_q == 2'h1) begin
        bw_d = hB0_q; // R7
        oe_d = 1'b1; // R6
        wStage_d = 2'h2;
      end else if (wStage_q == 2'h3) begin
        oe_d = 1'b0; // R18
        bw_d = '1;
        wStage_d = 2'h0;
      end
      if (st_q == dcsb_pkg::DCSB_CS_WAIT) begin
        gap_d = gap_q - 3'h1;
        if (gap_q == 3'h1) begin
          st_d = dcsb_pkg::DCSB_CS_IDLE;
        end
      end else if (reqValid) begin
        loadN_d = 1'b0; // R13
        rw_d = reqWrite ? dcsb_pkg::DCSB_RW_WRITE : dcsb_pkg::DCSB_RW_READ; // R13
        addr_d = reqAddr; // R1
        rdy_d = 1'b1;
        st_d = dcsb_pkg::DCSB_CS_WAIT;
        gap_d = reqWrite ? `DCSB_GAP_WRITE : `DCSB_GAP_READ; // R18
        if (reqWrite) begin
          wStage_d = 2'h1;
          dq_d = reqData0;
          hB0_d = reqByteN0;
          hD1_d = reqData1;
          hB1_d = reqByteN1;
        end
      end
    end else if (ph_d == PH_BEAT1 && wStage_q == 2'h2) begin
      dq_d = hD1_q; // R2
      bw_d = hB1_q; // R7
      wStage_d = 2'h3;
    end
  end

  // Write beats reach the bus only after the first true edge; the bus stays released before.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ph_q <= PH_LAST;
      kT_q <= 1'b0;
      kC_q <= 1'b1;
      st_q <= dcsb_pkg::DCSB_CS_IDLE;
      gap_q <= 3'h0;
      wStage_q <= 2'h0;
      loadN_q <= 1'b1;
      rw_q <= 1'b1;
      addr_q <= '0;
      bw_q <= '1;
      dq_q <= '0;
      oe_q <= 1'b0;
      hD1_q <= '0;
      hB0_q <= '1;
      hB1_q <= '1;
      rdy_q <= 1'b0;
      dll_q <= 1'b1;
    end else begin
      ph_q <= ph_d;
      kT_q <= kT_d;
      kC_q <= kC_d;
      st_q <= st_d;
      gap_q <= gap_d;
      wStage_q <= wStage_d;
      loadN_q <= loadN_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      bw_q <= bw_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      hD1_q <= hD1_d;
      hB0_q <= hB0_d;
      hB1_q <= hB1_d;
      rdy_q <= rdy_d;
      dll_q <= dll_d;
    end
  end

  // ----------------------------------------------------------------
  // Read capture on the echo clocks
  // ----------------------------------------------------------------
  always_comb begin
    r0_d = r0_q;
    r1_d = r1_q;
    got0_d = got0_q;
    rv_d = 1'b0;
    if (eT2_q && !eT3_q) begin
      got0_d = qv2_q; // R14
      if (qv2_q) begin
        r0_d = dqS2_q; // R11
      end
    end else if (eC2_q && !eC3_q && qv2_q && got0_q) begin
      r1_d = dqS2_q; // R3
      rv_d = 1'b1;
      got0_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r0_q <= '0;
      r1_q <= '0;
      got0_q <= 1'b0;
      rv_q <= 1'b0;
    end else begin
      r0_q <= r0_d;
      r1_q <= r1_d;
      got0_q <= got0_d;
      rv_q <= rv_d;
    end
  end

  assign link.inputClockTrue = kT_q;
  assign link.inputClockComp = kC_q;
  assign link.loadN = loadN_q;
  assign link.readWriteSel = rw_q;
  assign link.sramAddress = addr_q;
  assign link.byteWriteN = bw_q;
  assign link.dllOffN = dll_q;
  assign link.ctrlDqOut = dq_q;
  assign link.ctrlDqOe = oe_q;
  assign reqReady = rdy_q;
  assign rdValid = rv_q;
  assign rdData0 = r0_q;
  assign rdData1 = r1_q;
endmodule : dcsb_controller

// file: dcsb_device.sv
// Device end: the double-data-rate common-I/O memory with a burst of two and a late-write buffer.
// Assumes link pins asynchronous to sys_clk and a clock pair far slower than sys_clk.
`timescale 1ns/1ps
`include "dcsb_consts.svh"
module dcsb_device #(
  parameter bit WIDE_MODE = 1'b1
) (
  input wire logic sys_clk, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  dcsb_link_if.device link // Memory link.
);
  localparam int DW = WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW; // R10
  localparam int AW = WIDE_MODE ? `DCSB_AW_WIDE : `DCSB_AW_NARROW; // R10
  localparam int BW = `DCSB_BYTE_W;
  localparam int BN = DW / BW;

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  // Clocks, controls and data all pass the same two flops, so their mutual timing survives.
  logic kT1_q, kT2_q, kT3_q, kC1_q, kC2_q, kC3_q;
  logic ld1_q, ld2_q, rw1_q, rw2_q, dll1_q, dll2_q;
  logic [AW-1:0] a1_q, a2_q;
  logic [BN-1:0] b1_q, b2_q;
  logic [DW-1:0] d1_q, d2_q;

  always_ff @(posedge sys_clk) begin
    kT1_q <= link.inputClockTrue;
    kT2_q <= kT1_q;
    kT3_q <= kT2_q;
    kC1_q <= link.inputClockComp;
    kC2_q <= kC1_q;
    kC3_q <= kC2_q;
    ld1_q <= link.loadN;
    ld2_q <= ld1_q;
    rw1_q <= link.readWriteSel;
    rw2_q <= rw1_q;
    dll1_q <= link.dllOffN;
    dll2_q <= dll1_q;
    a1_q <= link.sramAddress;
    a2_q <= a1_q;
    b1_q <= link.byteWriteN;
    b2_q <= b1_q;
    d1_q <= link.dqBus;
    d2_q <= d1_q;
  end

  logic kRise, kcRise, dllOff;
  assign kRise = kT2_q && !kT3_q; // R8
  assign kcRise = kC2_q && !kC3_q; // R2
  assign dllOff = !dll2_q; // R15

  // ----------------------------------------------------------------
  // Pipeline, write buffer and output state
  // ----------------------------------------------------------------
  logic st1V_q, st1V_d, st2V_q, st2V_d;
  logic [AW-1:0] st1A_q, st1A_d, st2A_q, st2A_d;
  logic wCmd_q, wCmd_d;
  logic [AW-1:0] wA_q, wA_d;
  logic bufV_q, bufV_d, bufHalf_q, bufHalf_d;
  logic [AW-1:0] bufA_q, bufA_d;
  logic [DW-1:0] bufD0_q, bufD0_d, bufD1_q, bufD1_d;
  logic [BN-1:0] bufB0_q, bufB0_d, bufB1_q, bufB1_d;
  logic [DW-1:0] dqOut_q, dqOut_d, hold1_q, hold1_d;
  logic dqOe_q, dqOe_d, qv_q, qv_d, beat1P_q, beat1P_d;
  logic echoT_q, echoC_q;

  // ----------------------------------------------------------------
  // Array and coherent read merge
  // ----------------------------------------------------------------
  // Each entry holds both beats of a burst, the first beat in the low half.
  logic [2*DW-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] fetchA;
  logic fetchV, hit, memWe;
  logic [2*DW-1:0] memWord, oldWord, rdMerged, commitWord;

  assign fetchA = dllOff ? st1A_q : st2A_q; // R15
  assign fetchV = dllOff ? st1V_q : st2V_q; // R4
  assign memWord = mem[fetchA];
  assign oldWord = mem[bufA_q];
  assign hit = bufV_q && (bufA_q == fetchA); // R17
  assign memWe = kRise && bufV_q && !bufHalf_q; // R12

  // A read overtaking a buffered write sees its enabled bytes; a missing second beat is not merged.
  for (genvar i = 0; i < BN; i++) begin : g_byte
    assign rdMerged[i*BW +: BW] = (hit && !bufB0_q[i]) ? bufD0_q[i*BW +: BW] : memWord[i*BW +: BW]; // R17
    assign rdMerged[DW+i*BW +: BW] = (hit && !bufHalf_q && !bufB1_q[i]) ?
      bufD1_q[i*BW +: BW] : memWord[DW+i*BW +: BW]; // R17
    assign commitWord[i*BW +: BW] = bufB0_q[i] ? oldWord[i*BW +: BW] : bufD0_q[i*BW +: BW]; // R7
    assign commitWord[DW+i*BW +: BW] = bufB1_q[i] ? oldWord[DW+i*BW +: BW] : bufD1_q[i*BW +: BW]; // R7
  end

  // The array is not reset; only the buffered write ever updates it.
  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[bufA_q] <= commitWord; // R12
    end
  end

  // ----------------------------------------------------------------
  // Command, data and read return sequencing
  // ----------------------------------------------------------------
  // On a true-clock rise the completed write retires first, so the same buffer can take the next
  // write's first beat at that very edge; back-to-back writes therefore never stall.
  always_comb begin
    st1V_d = st1V_q;
    st1A_d = st1A_q;
    st2V_d = st2V_q;
    st2A_d = st2A_q;
    wCmd_d = wCmd_q;
    wA_d = wA_q;
    bufV_d = bufV_q;
    bufHalf_d = bufHalf_q;
    bufA_d = bufA_q;
    bufD0_d = bufD0_q;
    bufD1_d = bufD1_q;
    bufB0_d = bufB0_q;
    bufB1_d = bufB1_q;
    dqOut_d = dqOut_q;
    hold1_d = hold1_q;
    dqOe_d = dqOe_q;
    qv_d = qv_q;
    beat1P_d = beat1P_q;
    if (kRise) begin
      if (memWe) begin
        bufV_d = 1'b0;
      end
      if (wCmd_q) begin
        bufV_d = 1'b1; // R6
        bufHalf_d = 1'b1;
        bufA_d = wA_q;
        bufD0_d = d2_q; // R1
        bufB0_d = b2_q; // R7
        wCmd_d = 1'b0;
      end
      st2V_d = st1V_q;
      st2A_d = st1A_q;
      st1V_d = 1'b0;
      wCmd_d = 1'b0;
      if (!ld2_q) begin
        if (rw2_q == dcsb_pkg::DCSB_RW_READ) begin // R13
          st1V_d = 1'b1;
          st1A_d = a2_q; // R1
        end else begin
          wCmd_d = 1'b1;
          wA_d = a2_q; // R16
        end
      end
      if (fetchV) begin
        dqOut_d = rdMerged[DW-1:0]; // R4
        hold1_d = rdMerged[2*DW-1:DW]; // R3
        dqOe_d = 1'b1; // R9
        qv_d = 1'b1; // R14
        beat1P_d = 1'b1;
      end else begin
        dqOe_d = 1'b0; // R9
        qv_d = 1'b0; // R14
        beat1P_d = 1'b0;
      end
    end else if (kcRise) begin
      if (bufHalf_q) begin
        bufD1_d = d2_q; // R2
        bufB1_d = b2_q; // R7
        bufHalf_d = 1'b0;
      end
      if (beat1P_q) begin
        dqOut_d = hold1_q; // R5
        beat1P_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st1V_q <= 1'b0;
      st1A_q <= '0;
      st2V_q <= 1'b0;
      st2A_q <= '0;
      wCmd_q <= 1'b0;
      wA_q <= '0;
      bufV_q <= 1'b0;
      bufHalf_q <= 1'b0;
      bufA_q <= '0;
      bufD0_q <= '0;
      bufD1_q <= '0;
      bufB0_q <= '1;
      bufB1_q <= '1;
      dqOut_q <= '0;
      hold1_q <= '0;
      dqOe_q <= 1'b0;
      qv_q <= 1'b0;
      beat1P_q <= 1'b0;
    end else begin
      st1V_q <= st1V_d;
      st1A_q <= st1A_d;
      st2V_q <= st2V_d;
      st2A_q <= st2A_d;
      wCmd_q <= wCmd_d;
      wA_q <= wA_d;
      bufV_q <= bufV_d;
      bufHalf_q <= bufHalf_d;
      bufA_q <= bufA_d;
      bufD0_q <= bufD0_d;
      bufD1_q <= bufD1_d;
      bufB0_q <= bufB0_d;
      bufB1_q <= bufB1_d;
      dqOut_q <= dqOut_d;
      hold1_q <= hold1_d;
      dqOe_q <= dqOe_d;
      qv_q <= qv_d;
      beat1P_q <= beat1P_d;
    end
  end

  // ----------------------------------------------------------------
  // Echo clocks
  // ----------------------------------------------------------------
  // Echoes copy the sampled input pair on the edge that updates data and valid, so all stay
  // aligned; they run on while the bus is released.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      echoT_q <= 1'b0;
      echoC_q <= 1'b1;
    end else begin
      echoT_q <= kT2_q; // R11
      echoC_q <= kC2_q; // R11
    end
  end

  assign link.devDqOut = dqOut_q;
  assign link.devDqOe = dqOe_q;
  assign link.echoClockTrue = echoT_q;
  assign link.echoClockComp = echoC_q;
  assign link.readValidFlag = qv_q;
endmodule : dcsb_device

// file: dcsb_link_if.sv
// Link between the memory controller end and the memory device end.
// Assumes both ends share the configuration parameter; the shared data wire is resolved here.
`timescale 1ns/1ps
`include "dcsb_consts.svh"
interface dcsb_link_if #(
  parameter bit WIDE_MODE = 1'b1
);
  localparam int DW = WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW;
  localparam int AW = WIDE_MODE ? `DCSB_AW_WIDE : `DCSB_AW_NARROW;
  localparam int BN = DW / `DCSB_BYTE_W;

  logic inputClockTrue;
  logic inputClockComp;
  logic loadN;
  logic readWriteSel;
  logic [AW-1:0] sramAddress;
  logic [BN-1:0] byteWriteN;
  logic dllOffN;
  logic [DW-1:0] ctrlDqOut;
  logic ctrlDqOe;
  logic [DW-1:0] devDqOut;
  logic devDqOe;
  logic [DW-1:0] dqBus;
  logic echoClockTrue;
  logic echoClockComp;
  logic readValidFlag;

  // The device wins the wire while it drives; an idle wire reads as zero.
  assign dqBus = devDqOe ? devDqOut : (ctrlDqOe ? ctrlDqOut : '0);

  modport device (
    input inputClockTrue, inputClockComp, loadN, readWriteSel, sramAddress,
    input byteWriteN, dllOffN, dqBus,
    output devDqOut, devDqOe, echoClockTrue, echoClockComp, readValidFlag
  );

  modport controller (
    output inputClockTrue, inputClockComp, loadN, readWriteSel, sramAddress,
    output byteWriteN, dllOffN, ctrlDqOut, ctrlDqOe,
    input dqBus, echoClockTrue, echoClockComp, readValidFlag
  );
endinterface : dcsb_link_if

// file: dcsb_link_props.sv
// Checker for the link between both ends.
// Assumes the bench wires the link signals to it by name.
`timescale 1ns/1ps
`include "dcsb_consts.svh"
module dcsb_link_props #(
  parameter bit WIDE_MODE = 1'b1
) (
  input wire logic sys_clk, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic inputClockTrue, // True input clock.
  input wire logic inputClockComp, // Complement input clock.
  input wire logic loadN, // Load, low active.
  input wire logic readWriteSel, // High selects a read.
  input wire logic [(WIDE_MODE ? `DCSB_AW_WIDE : `DCSB_AW_NARROW)-1:0] sramAddress, // Burst address.
  input wire logic [(WIDE_MODE ? 4 : 2)-1:0] byteWriteN, // Byte enables, low active.
  input wire logic dllOffN, // Delay loop off, low.
  input wire logic [(WIDE_MODE ? `DCSB_DW_WIDE : `DCSB_DW_NARROW)-1:0] ctrlDqOut, // Write data.
  input wire logic ctrlDqOe, // Controller drive.
  input wire logic devDqOe, // Device drive.
  input wire logic echoClockTrue, // Echo clock.
  input wire logic echoClockComp, // Complement echo clock.
  input wire logic readValidFlag // Read data valid.
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Skewed pairs would capture beats on the wrong phase.
  chk_comp_clock_inverse: assert property (inputClockComp == !inputClockTrue)
    else $error("input clock pair not complementary");
  chk_echo_pair_inverse: assert property (echoClockComp == !echoClockTrue)
    else $error("echo clock pair not complementary");
  chk_bus_no_contention: assert property (!(devDqOe && ctrlDqOe))
    else $error("both ends drive the data bus");
  chk_valid_tracks_drive: assert property (readValidFlag == devDqOe)
    else $error("valid differs from drive");
  chk_valid_echo_aligned: assert property ($changed(readValidFlag) |-> $rose(echoClockTrue))
    else $error("valid moved off echo edge");
  // Counted from the pin rise, plus three cycles of sampling.
  chk_read_two_cycles: assert property ($rose(inputClockTrue) && !loadN && readWriteSel && dllOffN
    |-> ##[18:20] $rose(readValidFlag))
    else $error("two-cycle read latency wrong");
  chk_read_one_cycle: assert property ($rose(inputClockTrue) && !loadN && readWriteSel && !dllOffN
    |-> ##[10:12] $rose(readValidFlag))
    else $error("one-cycle read latency wrong");
  chk_read_two_beats: assert property ($rose(devDqOe) |-> devDqOe [*8] ##1 !devDqOe)
    else $error("read window not one period");
  chk_write_window: assert property ($rose(ctrlDqOe) |-> ctrlDqOe [*8] ##1 !ctrlDqOe)
    else $error("write window not one period");
  chk_cmd_stable_edge: assert property ($rose(inputClockTrue)
    |-> $stable(loadN) && $stable(readWriteSel) && $stable(sramAddress))
    else $error("command moved at true rise");
  chk_beat_stable_edge: assert property (($rose(inputClockTrue) || $rose(inputClockComp)) && ctrlDqOe
    |-> $stable(ctrlDqOut) && $stable(byteWriteN))
    else $error("write beat changed at its capture edge");
  chk_idle_enables_off: assert property (!ctrlDqOe |-> &byteWriteN)
    else $error("enables active outside write");
endmodule : dcsb_link_props

// file: dcsb_pkg.sv
// Types shared by both ends of the memory port.
// Assumes the constants header is on the include path.
package dcsb_pkg;
  // Direction select sampled while load is low.
  typedef enum logic {
    DCSB_RW_WRITE = 1'b0,
    DCSB_RW_READ = 1'b1
  } dcsb_rw_e;

  // Controller issue state; one bit keeps the sequence Gray.
  typedef enum logic {
    DCSB_CS_IDLE = 1'b0,
    DCSB_CS_WAIT = 1'b1
  } dcsb_ctrl_state_e;
endpackage : dcsb_pkg

// file: test_ddr_cio_sram_burst2_port.sv
// Bench joining both ends of the memory link, checked end to end.
// Assumes the package, interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
`include "dcsb_consts.svh"
module test_ddr_cio_sram_burst2_port;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [19:0] reqAddr = '0;
  logic [35:0] reqData0 = '0;
  logic [35:0] reqData1 = '0;
  logic [3:0] reqByteN0 = 4'hf;
  logic [3:0] reqByteN1 = 4'hf;
  logic dllOffReqN = 1'b1;
  logic reqReady;
  logic rdValid;
  logic [35:0] rdData0;
  logic [35:0] rdData1;
  logic [35:0] wBeat0, wBeat1, qBeat0, qBeat1;
  logic [3:0] wBw0, wBw1;
  logic pT = 1'b0, pC = 1'b1, pEt = 1'b0, pEc = 1'b1;
  int fail_count = 0;
  int samples_checked = 0;

  dcsb_link_if #(.WIDE_MODE(1'b1)) link ();
  dcsb_controller #(.WIDE_MODE(1'b1)) i_dcsb_controller (.sys_clk(sys_clk), .reset(reset), .link(link),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData0(reqData0), .reqData1(reqData1),
    .reqByteN0(reqByteN0), .reqByteN1(reqByteN1), .dllOffReqN(dllOffReqN), .reqReady(reqReady),
    .rdValid(rdValid), .rdData0(rdData0), .rdData1(rdData1));
  dcsb_device #(.WIDE_MODE(1'b1)) i_dcsb_device (.sys_clk(sys_clk), .reset(reset), .link(link));
  dcsb_link_props #(.WIDE_MODE(1'b1)) i_dcsb_link_props (.sys_clk(sys_clk), .reset(reset),
    .inputClockTrue(link.inputClockTrue), .inputClockComp(link.inputClockComp), .loadN(link.loadN),
    .readWriteSel(link.readWriteSel), .sramAddress(link.sramAddress), .byteWriteN(link.byteWriteN),
    .dllOffN(link.dllOffN), .ctrlDqOut(link.ctrlDqOut), .ctrlDqOe(link.ctrlDqOe), .devDqOe(link.devDqOe),
    .echoClockTrue(link.echoClockTrue), .echoClockComp(link.echoClockComp), .readValidFlag(link.readValidFlag));

  // Free-running 40 MHz system clock.
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Catches each bus beat at the edge that should capture it.
  always @(posedge sys_clk) begin
    pT <= link.inputClockTrue;
    pC <= link.inputClockComp;
    pEt <= link.echoClockTrue;
    pEc <= link.echoClockComp;
    if (link.inputClockTrue && !pT && link.ctrlDqOe) begin
      wBeat0 <= link.dqBus;
      wBw0 <= link.byteWriteN;
    end
    if (link.inputClockComp && !pC && link.ctrlDqOe) begin
      wBeat1 <= link.dqBus;
      wBw1 <= link.byteWriteN;
    end
    if (link.echoClockTrue && !pEt && link.readValidFlag) begin
      qBeat0 <= link.dqBus;
    end
    if (link.echoClockComp && !pEc && link.readValidFlag) begin
      qBeat1 <= link.dqBus;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [35:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  // Merges a write beat onto the old word; a low enable writes its byte.
  function automatic logic [35:0] merge_bytes(input logic [35:0] oldW, newW, input logic [3:0] bwN);
    merge_bytes = oldW;
    for (int b = 0; b < 4; b++) begin
      if (!bwN[b]) merge_bytes[9*b +: 9] = newW[9*b +: 9];
    end
  endfunction : merge_bytes

  // Holds the request until the controller takes it.
  task automatic issue(input logic wr, input logic [19:0] addr, input logic [35:0] d0, d1, input logic [3:0] b0, b1);
    int n;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = addr;
    reqData0 = d0;
    reqData1 = d1;
    reqByteN0 = b0;
    reqByteN1 = b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_word({35'h0, reqReady}, 36'h1, "request not taken");
    reqValid = 1'b0;
  endtask : issue

  task automatic check_beats(input logic [35:0] d0, d1, input logic [3:0] b0, b1);
    check_word(wBeat0, d0, "write beat 0");
    check_word({32'h0, wBw0}, {32'h0, b0}, "enables 0");
    check_word(wBeat1, d1, "write beat 1");
    check_word({32'h0, wBw1}, {32'h0, b1}, "enables 1");
  endtask : check_beats

  task automatic do_write(input logic [19:0] addr, input logic [35:0] d0, d1);
    issue(1'b1, addr, d0, d1, 4'h0, 4'h0);
    repeat (20) @(posedge sys_clk);
    check_beats(d0, d1, 4'h0, 4'h0);
  endtask : do_write

  task automatic do_read(input logic [19:0] addr, input logic [35:0] e0, e1);
    int n;
    qBeat0 = 'x;
    qBeat1 = 'x;
    issue(1'b0, addr, '0, '0, 4'hf, 4'hf);
    n = 0;
    while (rdValid !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_word({35'h0, rdValid}, 36'h1, "read not returned");
    check_word(rdData0, e0, "read beat 0");
    check_word(rdData1, e1, "read beat 1");
    check_word(qBeat0, e0, "echo beat 0");
    check_word(qBeat1, e1, "echo beat 1");
  endtask : do_read

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_full_burst();
    do_write(20'h00123, 36'h123456789, 36'h9abcdef01);
    do_read(20'h00123, 36'h123456789, 36'h9abcdef01);
  endtask : t_full_burst

  // Partial write over a full one; the read must show the bytes merged.
  task automatic t_byte_merge();
    do_write(20'h00456, 36'h0a1b2c3d4, 36'h5e6f70819);
    issue(1'b1, 20'h00456, 36'hfedcba987, 36'h876543210, 4'h5, 4'ha);
    do_read(20'h00456, merge_bytes(36'h0a1b2c3d4, 36'hfedcba987, 4'h5),
      merge_bytes(36'h5e6f70819, 36'h876543210, 4'ha));
    check_beats(36'hfedcba987, 36'h876543210, 4'h5, 4'ha);
  endtask : t_byte_merge

  // Bypassed delay loop at the top address; the checker times the latency.
  task automatic t_dll_off();
    @(posedge sys_clk);
    #1;
    dllOffReqN = 1'b0;
    repeat (16) @(posedge sys_clk);
    do_write(20'hfffff, 36'h3c3c3c3c3, 36'hc3c3c3c3c);
    do_read(20'hfffff, 36'h3c3c3c3c3, 36'hc3c3c3c3c);
    #1;
    dllOffReqN = 1'b1;
    repeat (16) @(posedge sys_clk);
    do_read(20'h00123, 36'h123456789, 36'h9abcdef01);
  endtask : t_dll_off

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_full_burst();
    t_byte_merge();
    t_dll_off();
    report_and_stop();
  end

  // Watchdog, far beyond the few hundred cycles needed.
  initial begin
    #(25 * 5000);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : test_ddr_cio_sram_burst2_port
